// file: logic/pir_top.v
// pci interrupt rerouting fabric top level
`timescale 1ns/1ps
module pir_top #(
   parameter NUM_SLOTS = 4,
   parameter APIC_INS  = 24
) (
   // clock and reset
   input  wire                 clk,
   input  wire                 reset,
   // mode select: high for apic delivery
   input  wire                 apic_mode,
   // pci interrupt sources, active low
   input  wire [NUM_SLOTS-1:0] slot_inta_n,
   input  wire                 chain_intb_n,
   input  wire                 chain_intc_n,
   input  wire                 chain_intd_n,
   input  wire                 scsi_int_n,
   input  wire                 nic_int_n,
   // legacy isa requests 0-15, active high
   input  wire [15:0]          isa_irq,
   // south bridge steering map, nibble per pci line
   input  wire [15:0]          sb_steer_map,
   // rerouter i/o port
   input  wire                 io_cs_n,
   input  wire [1:0]           io_addr,
   input  wire                 io_rd_n,
   input  wire                 io_wr_n,
   input  wire [7:0]           io_data_in,
   output reg  [7:0]           io_data_out,
   output reg                  io_data_oe_n,
   // processor side of compat controller
   input  wire                 proc_ack,
   input  wire                 proc_eoi,
   output wire                 processor_irq_line,
   output wire [3:0]           compat_vec,
   // redirection entry programming
   input  wire                 red_wr,
   input  wire [4:0]           red_idx,
   input  wire [9:0]           red_data,
   // apic bus
   output wire                 apic_clk,
   input  wire [1:0]           apic_d_in,
   output wire [1:0]           apic_d_out,
   output wire [1:0]           apic_d_oe_n,
   // error sources and gating
   input  wire [3:0]           err_evt,
   input  wire [3:0]           err_nmi_always,
   input  wire                 bmc_smi_n,
   input  wire                 smi_enable,
   input  wire                 serr_enable,
   // rerouted isa irq lines and error outputs
   output reg  [15:0]          isa_irq_out,
   output reg                  sys_mgmt_irq_n,
   output reg                  nmi,
   output reg                  serr_n
);
`include "pir_regs.vh"

   // rerouter control registers
   reg  [7:0]  reroute_ctrl_first_q;  // lines a and b
   reg  [7:0]  reroute_ctrl_second_q; // lines c and d

   // combined pci lines and routing decode
   reg  [3:0]  pci_line_q;     // a..d, active high
   wire [15:0] code_all;       // four nibbles, a low
   reg  [3:0]  pass_v;         // line goes to apic
   reg  [15:0] reroute_v;      // rerouted isa levels
   reg  [15:0] steer_v;        // south bridge steering
   reg  [15:0] compat_req_q;   // compat controller inputs
   reg  [APIC_INS-1:0] apic_req_q; // apic inputs
   wire        io_sel;         // port selected
   wire        reg_idx;        // aliased register index
   wire        irq_raw;        // compat line from controller
   wire [3:0]  vec_raw;        // compat level from controller
   reg         irq_q;          // registered shared line
   reg         sys_err;        // any system error
   reg         nmi_d;          // next nmi
   reg         smi_d;          // next smi
   integer     k;

   // register port

   // chip select comes already decoded from outside
   assign io_sel  = !io_cs_n;
   // only address bit 0 decoded, so four bytes alias two
   assign reg_idx = io_addr[0];

   // writes land in the addressed register
   always @(posedge clk) begin
      if (reset) begin
         reroute_ctrl_first_q <= `PIR_REG_RESET;
         reroute_ctrl_second_q <= `PIR_REG_RESET;
      end else if (io_sel && !io_wr_n) begin
         // full byte written, one nibble per line
         if (reg_idx == `PIR_REG_FIRST) begin
            reroute_ctrl_first_q <= io_data_in;
         end else begin
            reroute_ctrl_second_q <= io_data_in;
         end
      end
   end

   // reads return the aliased register
   always @(posedge clk) begin
      if (reset) begin
         io_data_out <= 8'h00;
         io_data_oe_n <= 1'b1;
      end else begin
         // drive only during a selected read
         io_data_oe_n <= !(io_sel && !io_rd_n);
         if (reg_idx == `PIR_REG_FIRST) begin
            io_data_out <= reroute_ctrl_first_q;
         end else begin
            io_data_out <= reroute_ctrl_second_q;
         end
      end
   end

   // pci source combining

   // wired-or of the shared active-low sources
   always @(posedge clk) begin
      if (reset) begin
         pci_line_q <= 4'h0;
      end else begin
         // every slot inta plus scsi onto line a
         pci_line_q[0] <= !(&slot_inta_n) || !scsi_int_n;
         // cascaded intb chain plus nic onto line b
         pci_line_q[1] <= !chain_intb_n || !nic_int_n;
         // cascaded chains onto lines c and d
         pci_line_q[2] <= !chain_intc_n;
         pci_line_q[3] <= !chain_intd_n;
      end
   end

   // rerouting decode

   assign code_all = {reroute_ctrl_second_q[`PIR_NIB_HI],
                      reroute_ctrl_second_q[`PIR_NIB_LO],
                      reroute_ctrl_first_q[`PIR_NIB_HI],
                      reroute_ctrl_first_q[`PIR_NIB_LO]};

   // each line decoded on its own nibble
   always @* begin
      pass_v = 4'h0;
      reroute_v = 16'h0000;
      steer_v = 16'h0000;
      for (k = 0; k < 4; k = k + 1) begin
         // code zero passes, others name an irq
         if (code_all[k*4 +: 4] == `PIR_CODE_PASS) begin
            pass_v[k] = pci_line_q[k];
         end else begin
            reroute_v[code_all[k*4 +: 4]] =
               reroute_v[code_all[k*4 +: 4]] | pci_line_q[k];
         end
         // south bridge steering, levels 1-15 only
         if (sb_steer_map[k*4 +: 4] != 4'h0) begin
            steer_v[sb_steer_map[k*4 +: 4]] =
               steer_v[sb_steer_map[k*4 +: 4]] | pci_line_q[k];
         end
      end
   end

   // delivery to compat controller, isa lines and apic

   // registered request vectors
   always @(posedge clk) begin
      if (reset) begin
         compat_req_q <= 16'h0000;
         apic_req_q <= {APIC_INS{1'b0}};
         isa_irq_out <= 16'h0000;
      end else begin
         // rerouted lines appear as real isa irqs
         isa_irq_out <= reroute_v;
         // steered lines reach the controller only
         compat_req_q <= isa_irq | reroute_v | steer_v;
         // isa levels keep their numbers at the apic
         apic_req_q[15:0] <= isa_irq | reroute_v;
         // pass-through lines on 16-19, never steered ones
         apic_req_q[19:16] <= pass_v;
         apic_req_q[APIC_INS-1:20] <= {(APIC_INS-20){1'b0}};
      end
   end

   // cascaded compatibility controllers
   pir_compat_ctrl u_compat (
      .clk   (clk),
      .reset (reset),
      .req   (compat_req_q),
      .ack   (proc_ack),
      .eoi   (proc_eoi),
      .irq_q (irq_raw),
      .vec_q (vec_raw)
   );

   // shared line only in compat mode
   always @(posedge clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_raw && !apic_mode;
      end
   end

   assign processor_irq_line = irq_q;
   assign compat_vec = vec_raw;

   // i/o apic and its serial bus
   pir_apic_tx #(
      .N (APIC_INS)
   ) u_apic (
      .clk         (clk),
      .reset       (reset),
      .enable      (apic_mode),
      .req         (apic_req_q),
      .red_wr      (red_wr),
      .red_idx     (red_idx),
      .red_data    (red_data),
      .apic_clk_q  (apic_clk),
      .apic_d_in   (apic_d_in),
      .apic_d_out  (apic_d_out),
      .apic_d_oe_n (apic_d_oe_n)
   );

   // error signalling

   // choose smi or nmi for system errors
   always @* begin
      sys_err = |err_evt;
      if (smi_enable) begin
         // intercepted, preprocessing by smi handler
         smi_d = sys_err || !bmc_smi_n;
         // some errors still need nmi
         nmi_d = |(err_evt & err_nmi_always);
      end else begin
         // handled straight through nmi
         smi_d = 1'b0;
         nmi_d = sys_err;
      end
   end

   // registered error outputs and serr gating
   always @(posedge clk) begin
      if (reset) begin
         sys_mgmt_irq_n <= 1'b1;
         nmi <= 1'b0;
         serr_n <= 1'b1;
      end else begin
         sys_mgmt_irq_n <= !smi_d;
         nmi <= nmi_d;
         // serr formed from gated smi and nmi
         serr_n <= !(serr_enable && (smi_d || nmi_d));
      end
   end
endmodule

// file: logic/pir_regs.vh
// constants for the pci interrupt rerouting fabric
// Functional notes
// - secondary levels 8-15 cascade onto primary level 2
// - one shared processor interrupt line in compat mode
// - pci lines steerable to compat levels 1-15 only
// - apic mode: requests become apic bus messages
// - apic bus: one clock, two bidirectional data lines
// - 24 apic inputs; levels 0-15 map one-to-one
// - pass-through pci a-d land on apic 16-19
// - each apic input owns a redirection entry
// - internal steering never reaches the apic
// - rerouter: pass-through or chosen isa irq
// - each pci line routed independently
// - two 8-bit registers, one nibble per line
// - two registers alias across four-byte range
// - combine slot, scsi and nic interrupts
// - smi intercepts errors when enabled, else nmi
// - some errors raise nmi despite smi
// - non-isa errors shown as nmi/smi events
// - gated smi and nmi produce serr
`ifndef PIR_REGS_VH
`define PIR_REGS_VH

// rerouter register index (address bit 0 only)
`define PIR_REG_FIRST        1'h0
`define PIR_REG_SECOND       1'h1
`define PIR_REG_RESET        8'h00
// nibble layout inside a register
`define PIR_NIB_LO           3:0
`define PIR_NIB_HI           7:4
// routing code meaning pass-through
`define PIR_CODE_PASS        4'h0
// first apic input fed by pci line a
`define PIR_APIC_PCI_BASE    5'h10
// compat cascade level on the primary
`define PIR_CASCADE_LEVEL    3'h2
// redirection entry fields
`define PIR_RED_VEC          7:0
`define PIR_RED_LEVEL        8
`define PIR_RED_MASK         9
`define PIR_RED_RESET        10'h200
// apic bus timing
`define PIR_CLK_NS           10
`define PIR_APIC_CLK_NS      60
// apic message length in bits
`define PIR_MSG_BITS         5'h10

`endif

// file: logic/pir_compat_ctrl.v
// cascaded pair of compatibility interrupt controllers
`timescale 1ns/1ps
module pir_compat_ctrl (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // request levels 0-15
   input  wire [15:0] req,
   // processor acknowledge and end of interrupt
   input  wire        ack,
   input  wire        eoi,
   // shared interrupt line and chosen level
   output reg         irq_q,
   output reg  [3:0]  vec_q
);
`include "pir_regs.vh"

   reg  [15:0] isr_q;   // in-service levels
   wire [7:0]  pri_req; // primary view of requests
   wire [7:0]  sec_req; // secondary requests
   reg  [3:0]  pick;    // level chosen at acknowledge
   wire [3:0]  sec_pick; // lowest requesting secondary level

   // lowest set bit of eight wins
   function [3:0] first8;
      input [7:0] v;
      integer i;
      begin
         first8 = 4'h8;
         for (i = 7; i >= 0; i = i - 1) begin
            if (v[i]) begin
               first8 = i[3:0];
            end
         end
      end
   endfunction

   // secondary feeds primary level two
   assign sec_req = req[15:8];
   assign pri_req = {req[7:3], |sec_req, req[1:0]};
   assign sec_pick = first8(sec_req);

   // resolve primary then secondary
   always @* begin
      pick = first8(pri_req);
      if (pick[2:0] == `PIR_CASCADE_LEVEL && !pick[3]) begin
         pick = {1'b1, sec_pick[2:0]};
      end
   end

   // one request serviced at a time
   always @(posedge clk) begin
      if (reset) begin
         isr_q <= 16'h0000;
         irq_q <= 1'b0;
         vec_q <= 4'h0;
      end else begin
         // single line to processors
         irq_q <= (|pri_req) && (isr_q == 16'h0000) && !ack;
         if (ack && (|pri_req)) begin
            vec_q <= pick;
            isr_q <= 16'h0001 << pick;
         end else if (eoi) begin
            isr_q <= 16'h0000;
         end
      end
   end
endmodule

// file: logic/pir_apic_tx.v
// i/o apic with redirection entries and serial bus sender
`timescale 1ns/1ps
module pir_apic_tx #(
   parameter N = 24
) (
   // clock and reset
   input  wire         clk,
   input  wire         reset,
   // enable of apic delivery
   input  wire         enable,
   // request inputs
   input  wire [N-1:0] req,
   // redirection entry write port
   input  wire         red_wr,
   input  wire [4:0]   red_idx,
   input  wire [9:0]   red_data,
   // apic bus
   output reg          apic_clk_q,
   input  wire [1:0]   apic_d_in,
   output reg  [1:0]   apic_d_out,
   output reg  [1:0]   apic_d_oe_n
);
`include "pir_regs.vh"

   // half period of apic clock in system clocks
   localparam integer HALF_I = (`PIR_APIC_CLK_NS / `PIR_CLK_NS) / 2;
   localparam [3:0] HALF = HALF_I[3:0];
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_WAIT = 3'b010;
   localparam [2:0] S_SEND = 3'b100;

   reg  [9:0]   red_q [0:N-1]; // redirection entries
   reg  [N-1:0] req_q;         // previous requests
   reg  [N-1:0] pend_q;        // awaiting delivery
   reg  [N-1:0] irr_q;         // level message outstanding
   reg  [N-1:0] set_v;         // new requests
   reg  [N-1:0] clr_v;         // delivered this cycle
   reg  [3:0]   div_q;         // clock divider
   reg  [2:0]   st_q;          // sender state
   reg  [4:0]   cnt_q;         // bits left
   reg  [15:0]  sh_q;          // outgoing message
   reg  [4:0]   sel;           // chosen input
   reg          any;           // something pending
   wire         fall;          // apic clock falls now
   integer      i;             // scan index, decode only
   integer      j;             // reset loop index

   assign fall = (div_q == HALF - 4'h1) && apic_clk_q;

   // watch inputs; edge or level per entry
   always @* begin
      sel = 5'h00;
      any = 1'b0;
      set_v = {N{1'b0}};
      clr_v = {N{1'b0}};
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (!red_q[i][`PIR_RED_MASK] && req[i]) begin
            if (red_q[i][`PIR_RED_LEVEL] ? !irr_q[i] : !req_q[i]) begin
               set_v[i] = 1'b1;
            end
         end
         if (pend_q[i]) begin
            sel = i[4:0];
            any = 1'b1;
         end
      end
      // retire only when the message really starts on an idle bus
      if (st_q == S_WAIT && fall && apic_d_in == 2'b11) begin
         clr_v[sel] = 1'b1;
      end
   end

   // entries, pending and message framing
   always @(posedge clk) begin
      if (reset) begin
         for (j = 0; j < N; j = j + 1) begin
            red_q[j] <= `PIR_RED_RESET;
         end
         req_q <= {N{1'b0}};
         pend_q <= {N{1'b0}};
         irr_q <= {N{1'b0}};
         div_q <= 4'h0;
         apic_clk_q <= 1'b0;
         st_q <= S_IDLE;
         cnt_q <= 5'h00;
         sh_q <= 16'h0000;
         apic_d_out <= 2'b00;
         apic_d_oe_n <= 2'b11;
      end else begin
         if (red_wr && red_idx < N) begin
            red_q[red_idx] <= red_data;
         end
         req_q <= req;
         // new event beats delivery clear
         pend_q <= (pend_q & ~clr_v) | (enable ? set_v : {N{1'b0}});
         irr_q <= (irr_q | clr_v) & req;
         // free running bus clock
         if (div_q == HALF - 4'h1) begin
            div_q <= 4'h0;
            apic_clk_q <= !apic_clk_q;
         end else begin
            div_q <= div_q + 4'h1;
         end
         case (st_q)
            S_IDLE: begin
               apic_d_oe_n <= 2'b11;
               if (any && enable) begin
                  st_q <= S_WAIT;
               end
            end
            S_WAIT: begin
               // start only on an idle bus
               if (fall && apic_d_in == 2'b11) begin
                  sh_q <= {red_q[sel][`PIR_RED_VEC], sel,
                           red_q[sel][`PIR_RED_LEVEL], 2'b00};
                  cnt_q <= `PIR_MSG_BITS;
                  apic_d_oe_n <= 2'b10; // start bit low on line 0
                  st_q <= S_SEND;
               end
            end
            S_SEND: begin
               if (fall) begin
                  // open drain: enable only for zeros
                  if (cnt_q == 5'h00) begin
                     apic_d_oe_n <= 2'b11;
                     st_q <= S_IDLE;
                  end else begin
                     apic_d_oe_n <= sh_q[15:14];
                     sh_q <= {sh_q[13:0], 2'b11};
                     cnt_q <= cnt_q - 5'h02;
                  end
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// file: testbench/pir_top_props.sv
// assertion checker for the rerouting fabric top level
`timescale 1ns/1ps
module pir_top_props (
   // clock and reset
   input wire logic       clk,
   input wire logic       reset,
   // watched inputs
   input wire logic       apic_mode,
   input wire logic       io_cs_n,
   input wire logic       io_rd_n,
   input wire logic [3:0] err_evt,
   input wire logic [3:0] err_nmi_always,
   input wire logic       bmc_smi_n,
   input wire logic       smi_enable,
   input wire logic       serr_enable,
   // watched outputs
   input wire logic       io_data_oe_n,
   input wire logic       processor_irq_line,
   input wire logic       apic_clk,
   input wire logic [1:0] apic_d_out,
   input wire logic [1:0] apic_d_oe_n,
   input wire logic       sys_mgmt_irq_n,
   input wire logic       nmi,
   input wire logic       serr_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // apic clock halves of three system clocks
   sequence s_hi3;
      apic_clk [*3];
   endsequence
   sequence s_lo3;
      !apic_clk [*3];
   endsequence
   // errors held with serr gating open and smi off
   sequence s_err3;
      (serr_enable && !smi_enable && |err_evt) [*3];
   endsequence
   property p_rd_oe;
      (!io_cs_n && !io_rd_n) |=> !io_data_oe_n;
   endproperty
   property p_oe_rel;
      io_cs_n |=> io_data_oe_n;
   endproperty
   property p_err_nmi;
      (!smi_enable && |err_evt) |=> nmi;
   endproperty
   property p_smi;
      (smi_enable && (|err_evt || !bmc_smi_n)) |=> !sys_mgmt_irq_n;
   endproperty
   property p_nmi_force;
      (smi_enable && |(err_evt & err_nmi_always)) |=> nmi;
   endproperty
   property p_serr_off;
      !serr_enable |=> serr_n;
   endproperty
   property p_serr_on;
      s_err3 |-> !serr_n;
   endproperty
   property p_compat_quiet;
      apic_mode [*3] |-> !processor_irq_line;
   endproperty
   property p_apic_clk;
      $rose(apic_clk) |-> s_hi3 ##1 s_lo3;
   endproperty
   property p_open_drain;
      (apic_d_oe_n != 2'b11) |-> apic_d_out == 2'b00;
   endproperty
   a_rd_oe: assert property (p_rd_oe)
      else $error("read port not driving");
   a_oe_rel: assert property (p_oe_rel)
      else $error("read port not released");
   a_err_nmi: assert property (p_err_nmi)
      else $error("error without nmi");
   a_smi: assert property (p_smi)
      else $error("error without smi");
   a_nmi_force: assert property (p_nmi_force)
      else $error("forced nmi missing");
   a_serr_off: assert property (p_serr_off)
      else $error("serr while gated off");
   a_serr_on: assert property (p_serr_on)
      else $error("serr missing");
   a_compat_quiet: assert property (p_compat_quiet)
      else $error("shared line active in apic mode");
   a_apic_clk: assert property (p_apic_clk)
      else $error("apic clock period wrong");
   a_open_drain: assert property (p_open_drain)
      else $error("apic bus driven high");
endmodule
bind pir_top pir_top_props chk_u (.clk(clk), .reset(reset),
   .apic_mode(apic_mode), .io_cs_n(io_cs_n), .io_rd_n(io_rd_n),
   .err_evt(err_evt), .err_nmi_always(err_nmi_always),
   .bmc_smi_n(bmc_smi_n), .smi_enable(smi_enable),
   .serr_enable(serr_enable), .io_data_oe_n(io_data_oe_n),
   .processor_irq_line(processor_irq_line), .apic_clk(apic_clk),
   .apic_d_out(apic_d_out), .apic_d_oe_n(apic_d_oe_n),
   .sys_mgmt_irq_n(sys_mgmt_irq_n), .nmi(nmi), .serr_n(serr_n));

// file: testbench/pir_proc_model.sv
// processor side model: answers the shared line, resolves apic bus
`timescale 1ns/1ps
module pir_proc_model #(
   parameter DLY = 2
) (
   // clock
   input  wire logic       clk,
   // shared line and apic bus pull enables
   input  wire logic       irq_line,
   input  wire logic [1:0] bus_oe_n,
   // acknowledge, end of interrupt, resolved bus
   output logic            ack,
   output logic            eoi,
   output wire logic [1:0] bus_in
);
   // pulled-up lines sit low only where someone pulls
   assign bus_in = bus_oe_n;
   // one responder: ack, service, retire
   initial begin
      ack = 1'b0;
      eoi = 1'b0;
      forever begin
         @(negedge clk);
         if (irq_line === 1'b1) begin
            repeat (DLY) @(negedge clk);
            ack = 1'b1;
            @(negedge clk);
            ack = 1'b0;
            repeat (DLY + 3) @(negedge clk);
            eoi = 1'b1;
            @(negedge clk);
            eoi = 1'b0;
            repeat (4) @(negedge clk);
         end
      end
   end
endmodule

// file: testbench/tb.sv
// self-checking bench for the rerouting fabric
`timescale 1ns/1ps
module tb;
   // design inputs
   logic        clk, reset, apic_mode, io_cs_n, io_rd_n, io_wr_n;
   logic [3:0]  slot_inta_n, err_evt, err_nmi_always;
   logic        chain_intb_n, chain_intc_n, chain_intd_n;
   logic        scsi_int_n, nic_int_n, bmc_smi_n, smi_enable;
   logic        serr_enable, red_wr, sm, nm;
   logic [15:0] isa_irq, sb_steer_map;
   logic [1:0]  io_addr;
   logic [7:0]  io_data_in, v;
   logic [4:0]  red_idx;
   logic [9:0]  red_data;
   // partner and design outputs
   wire         proc_ack, proc_eoi, io_data_oe_n, processor_irq_line;
   wire         apic_clk, sys_mgmt_irq_n, nmi, serr_n;
   wire [1:0]   apic_d_in, apic_d_out, apic_d_oe_n;
   wire [7:0]   io_data_out;
   wire [3:0]   compat_vec;
   wire [15:0]  isa_irq_out;
   // bookkeeping
   int          n_fail = 0;
   int          compares = 0;
   int          i, j, n, k, hits;
   logic [7:0]  exp_q[$];

   pir_top dut_u (.clk(clk), .reset(reset), .apic_mode(apic_mode),
      .slot_inta_n(slot_inta_n), .chain_intb_n(chain_intb_n),
      .chain_intc_n(chain_intc_n), .chain_intd_n(chain_intd_n),
      .scsi_int_n(scsi_int_n), .nic_int_n(nic_int_n), .isa_irq(isa_irq),
      .sb_steer_map(sb_steer_map), .io_cs_n(io_cs_n), .io_addr(io_addr),
      .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_data_in(io_data_in),
      .io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n),
      .proc_ack(proc_ack), .proc_eoi(proc_eoi),
      .processor_irq_line(processor_irq_line), .compat_vec(compat_vec),
      .red_wr(red_wr), .red_idx(red_idx), .red_data(red_data),
      .apic_clk(apic_clk), .apic_d_in(apic_d_in),
      .apic_d_out(apic_d_out), .apic_d_oe_n(apic_d_oe_n),
      .err_evt(err_evt), .err_nmi_always(err_nmi_always),
      .bmc_smi_n(bmc_smi_n), .smi_enable(smi_enable),
      .serr_enable(serr_enable), .isa_irq_out(isa_irq_out),
      .sys_mgmt_irq_n(sys_mgmt_irq_n), .nmi(nmi), .serr_n(serr_n));
   pir_proc_model #(.DLY(2)) proc_u (.clk(clk),
      .irq_line(processor_irq_line), .bus_oe_n(apic_d_oe_n),
      .ack(proc_ack), .eoi(proc_eoi), .bus_in(apic_d_in));

   // value and read-data comparisons
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   // verdict and end of run
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   // one-cycle port write and read
   task automatic io_wr(input logic [1:0] a, input logic [7:0] d);
      @(negedge clk);
      io_cs_n = 1'b0;
      io_wr_n = 1'b0;
      io_addr = a;
      io_data_in = d;
      @(negedge clk);
      io_cs_n = 1'b1;
      io_wr_n = 1'b1;
   endtask
   task automatic io_rd(input logic [1:0] a, input logic [7:0] e);
      @(negedge clk);
      io_cs_n = 1'b0;
      io_rd_n = 1'b0;
      io_addr = a;
      exp_q.push_back(e);
      @(negedge clk);
      io_cs_n = 1'b1;
      io_rd_n = 1'b1;
   endtask
   // bounded wait for the processor acknowledge
   task automatic wait_ack();
      int t;
      t = 0;
      while (proc_ack !== 1'b1 && t < 80) begin
         @(posedge clk);
         t++;
      end
      chk(16'(t < 80), 16'h1);
      cyc(3);
   endtask
   // count cycles with the apic bus pulled
   task automatic bus_busy(input int len, output int h);
      h = 0;
      repeat (len) begin
         @(negedge clk);
         if (apic_d_oe_n !== 2'b11) h++;
      end
   endtask

   // read data is checked whenever the port drives
   always @(negedge clk) begin
      if (io_data_oe_n === 1'b0) begin
         if (exp_q.size() == 0) chk_rd(io_data_out, 8'hxx);
         else chk_rd(io_data_out, exp_q.pop_front());
      end
   end
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog
   initial begin
      #400000;
      n_fail++;
      final_report();
   end
   // main sequence
   initial begin
      void'($urandom(54819));
      {reset, apic_mode, bmc_smi_n, io_cs_n, io_rd_n, io_wr_n} = 6'h3f;
      {chain_intb_n, chain_intc_n, chain_intd_n} = 3'h7;
      {scsi_int_n, nic_int_n, slot_inta_n} = 6'h3f;
      {isa_irq, sb_steer_map, io_addr, io_data_in} = '0;
      {red_wr, red_idx, red_data, smi_enable, serr_enable} = '0;
      {err_evt, err_nmi_always} = 8'h00;
      cyc(10);
      reset = 1'b0;
      // reset contents, then writes read back through aliases
      for (i = 0; i < 4; i++) io_rd(2'(i), 8'h00);
      for (i = 0; i < 6; i++) begin
         v = 8'($urandom);
         io_wr(2'(i), v);
         io_rd(2'(i) ^ 2'b10, v);
      end
      // error gating with random sources
      for (i = 0; i < 16; i++) begin
         @(negedge clk);
         {smi_enable, serr_enable, bmc_smi_n} = 3'($urandom);
         {err_evt, err_nmi_always} = 8'($urandom);
         cyc(3);
         sm = smi_enable & (|err_evt | ~bmc_smi_n);
         nm = smi_enable ? |(err_evt & err_nmi_always) : |err_evt;
         chk(16'({sys_mgmt_irq_n, nmi, serr_n}),
             16'({~sm, nm, ~(serr_enable & (sm | nm))}));
      end
      {err_evt, smi_enable, bmc_smi_n} = 6'h01;
      // every nonzero routing code, all lines requesting
      for (n = 1; n < 16; n++) begin
         k = n % 4;
         io_wr({1'($urandom), 1'(k / 2)}, 8'(n << (4 * (k % 2))));
         io_wr({1'($urandom), 1'(1 - k / 2)}, 8'h00);
         j = $urandom % 5;
         slot_inta_n = 4'(~(5'h1 << j));
         scsi_int_n = (j != 4);
         nic_int_n = 1'($urandom);
         chain_intb_n = ~nic_int_n;
         {chain_intc_n, chain_intd_n} = 2'b00;
         cyc(3);
         chk(isa_irq_out, 16'h1 << n);
         {slot_inta_n, scsi_int_n, nic_int_n} = 6'h3f;
         {chain_intb_n, chain_intc_n, chain_intd_n} = 3'h7;
         cyc(3);
         chk(isa_irq_out, 16'h0000);
      end
      // compat mode: cascade and steering
      apic_mode = 1'b0;
      isa_irq = 16'h0208;
      wait_ack();
      chk(16'(compat_vec), 16'h9);
      isa_irq = 16'h0000;
      cyc(20);
      sb_steer_map = 16'h0006;
      slot_inta_n = 4'he;
      wait_ack();
      chk(16'(compat_vec), 16'h6);
      chk(isa_irq_out, 16'h0000);
      slot_inta_n = 4'hf;
      sb_steer_map = 16'h0000;
      cyc(20);
      // apic mode: masked entry stays silent, unmasked one sends
      io_wr(2'h0, 8'h00);
      io_wr(2'h1, 8'h00);
      apic_mode = 1'b1;
      slot_inta_n = 4'he;
      bus_busy(100, hits);
      chk(16'(hits), 16'h0);
      slot_inta_n = 4'hf;
      red_wr = 1'b1;
      red_idx = 5'h10;
      red_data = {2'b00, 8'($urandom)};
      cyc(1);
      red_wr = 1'b0;
      cyc(3);
      slot_inta_n = 4'he;
      bus_busy(200, hits);
      chk(16'(hits > 0), 16'h1);
      slot_inta_n = 4'hf;
      cyc(50);
      final_report();
   end
endmodule
